// file: core/cbc_top.sv
/*
  Cell balance control: passive bypass of cells, autonomous or host driven,
  with measurement-loop suspension, loop slowing and die temperature cutoff.
  Assumes measurement, temperature and register strobes on this clock.
*/
// Function
// - bypass current around selected cells while charging or at rest
// - drive on-chip switches or external transistors as configured
// - autonomous mode picks only non-adjacent cells in use
// - never balance more cells at once than the maximum count
// - host starts and steers balancing with balancing commands
// - host may balance any cell combination up to the maximum count, adjacent ones too
// - host balancing runs a timer and stops at the limit
// - every new balancing command restarts the timer from zero
// - keep balancing time per cell, readable by the host
// - suspend a cell's bypass while that cell is sampled
// - suspend a cell's bypass while a neighbour is sampled
// - suspend top cell bypass while the stack is measured
// - when enabled and balancing, lengthen the measurement loop
// - when slowed, request a current-only conversion after each scan loop
// - stop all balancing while die temperature exceeds threshold
// - thermistor conversion lasts 3 ms, or 1.5 ms when fast
`include "cbc_params.svh"

module cbc_top
  import cbc_pkg::*;
#(
  parameter int TICK_CYC = `CBC_TICK_MS * `CBC_CLK_KHZ,
  parameter int THERM_CYC = `CBC_THERM_US * `CBC_CLK_KHZ / 1000
)
(
  input wire logic clock,
  input wire logic srst,
  input wire logic [7:0] addr,
  input wire logic [31:0] wdata,
  input wire logic wr,
  input wire logic rd,
  output logic [31:0] rdata,
  input wire cbc_pkg::cbc_mask_t want_mask,
  input wire logic meas_cell_valid,
  input wire logic [2:0] meas_cell_idx,
  input wire logic meas_stack,
  input wire logic loop_done,
  input wire logic [11:0] die_temp,
  input wire logic die_temp_valid,
  input wire logic therm_start,
  output cbc_pkg::cbc_mask_t int_sw,
  output cbc_pkg::cbc_mask_t ext_fet,
  output logic cur_only_req,
  output logic therm_busy
);
  import cbc_pkg::*;

  logic [3:0] ctrl;
  logic [3:0] next_ctrl;
  cbc_cnt_t max_cnt;
  cbc_cnt_t next_max_cnt;
  cbc_mask_t in_use;
  cbc_mask_t next_in_use;
  logic [15:0] host_lim;
  logic [15:0] next_host_lim;
  logic [11:0] temp_lim;
  logic [11:0] next_temp_lim;
  cbc_hst_t host_st;
  cbc_hst_t next_host_st;
  cbc_mask_t host_mask;
  cbc_mask_t next_host_mask;
  logic [26:0] host_pre;
  logic [26:0] next_host_pre;
  logic [15:0] host_sec;
  logic [15:0] next_host_sec;
  logic [26:0] free_pre;
  logic [26:0] next_free_pre;
  logic hot;
  logic next_hot;
  cbc_mask_t act;
  cbc_mask_t next_act;
  cbc_mask_t next_int_sw;
  cbc_mask_t next_ext_fet;
  logic next_cur_only;
  logic [18:0] therm_cnt;
  logic [18:0] next_therm_cnt;
  logic next_therm_busy;
  logic [31:0] next_rdata;
  logic cmd_wr;
  logic free_tick;
  logic host_tick;
  cbc_mask_t susp;
  cbc_mask_t top_oh;
  cbc_mask_t want_sel;
  logic [15:0] time_rd;
  logic [2:0] time_idx;
  logic time_hit;

  cbc_sel_if sif ();

  assign sif.want = want_mask;
  assign sif.in_use = in_use;
  assign sif.max_cnt = max_cnt;

  cbc_autosel u_autosel (
    .clock(clock),
    .srst(srst),
    .sif(sif)
  );

  // time registers sit on consecutive words
  assign time_idx = 3'((addr - `CBC_A_TIME0) >> 2);
  assign time_hit = addr >= `CBC_A_TIME0 && addr <= `CBC_A_TIME4 && addr[1:0] == 2'h0;

  cbc_baltime u_baltime (
    .clock(clock),
    .srst(srst),
    .tick(free_tick),
    .act(act),
    .clr(wr && time_hit),
    .idx(time_idx),
    .rd_data(time_rd)
  );

  // configuration registers
  always_comb
  begin
    next_ctrl = ctrl;
    next_max_cnt = max_cnt;
    next_in_use = in_use;
    next_host_lim = host_lim;
    next_temp_lim = temp_lim;
    if (wr)
    begin
      unique case (addr)
        `CBC_A_CTRL: next_ctrl = wdata[3:0];
        `CBC_A_MAXCNT: next_max_cnt = wdata[2:0];
        `CBC_A_INUSE: next_in_use = wdata[4:0];
        `CBC_A_HOSTLIM: next_host_lim = wdata[15:0];
        `CBC_A_TEMPLIM: next_temp_lim = wdata[11:0];
        default: ;
      endcase
    end
  end

  always_ff @(posedge clock)
  begin
    if (srst)
    begin
      ctrl <= `CBC_RST_CTRL;
      max_cnt <= `CBC_RST_MAXCNT;
      in_use <= `CBC_RST_INUSE;
      host_lim <= `CBC_RST_HOSTLIM;
      temp_lim <= `CBC_RST_TEMPLIM;
    end
    else
    begin
      ctrl <= next_ctrl;
      max_cnt <= next_max_cnt;
      in_use <= next_in_use;
      host_lim <= next_host_lim;
      temp_lim <= next_temp_lim;
    end
  end

  // host command, duration timer and free second tick
  assign cmd_wr = wr && addr == `CBC_A_HOSTCMD;
  assign host_tick = host_pre == 27'(TICK_CYC - 1);
  assign free_tick = free_pre == 27'(TICK_CYC - 1);

  always_comb
  begin
    next_host_st = host_st;
    next_host_mask = host_mask;
    next_host_pre = host_tick ? 27'h0 : host_pre + 27'h1;
    next_host_sec = host_sec + {15'h0, host_tick};
    next_free_pre = free_tick ? 27'h0 : free_pre + 27'h1;
    if (cmd_wr)
    begin
      next_host_mask = wdata[4:0];
      next_host_st = |wdata[4:0] ? CBC_HOST : CBC_IDLE;
      next_host_pre = 27'h0;
      next_host_sec = 16'h0000;
    end
    else
    begin
      unique case (host_st)
        CBC_IDLE:
        begin
          next_host_pre = 27'h0;
          next_host_sec = 16'h0000;
        end
        CBC_HOST:
        begin
          if (host_sec >= host_lim)
          begin
            next_host_st = CBC_IDLE;
            next_host_mask = '0;
          end
        end
      endcase
    end
  end

  always_ff @(posedge clock)
  begin
    if (srst)
    begin
      host_st <= CBC_IDLE;
      host_mask <= '0;
      host_pre <= 27'h0;
      host_sec <= 16'h0000;
      free_pre <= 27'h0;
    end
    else
    begin
      host_st <= next_host_st;
      host_mask <= next_host_mask;
      host_pre <= next_host_pre;
      host_sec <= next_host_sec;
      free_pre <= next_free_pre;
    end
  end

  // suspension by the measurement loop, top cell is the highest in use
  always_comb
  begin
    top_oh = '0;
    susp = '0;
    for (int i = 0; i < 5; i++)
    begin
      if (in_use[i])
        top_oh = cbc_mask_t'(5'h01 << i);
    end
    for (int i = 0; i < 5; i++)
    begin
      if (meas_cell_valid && meas_cell_idx == 3'(i))
        susp[i] = 1'b1;
      if (meas_cell_valid && (meas_cell_idx == 3'(i + 1) || meas_cell_idx + 3'h1 == 3'(i)))
        susp[i] = 1'b1;
      if (meas_stack && top_oh[i])
        susp[i] = 1'b1;
    end
  end

  // final selection, cap, temperature cutoff and switch routing
  always_comb
  begin
    want_sel = '0;
    if (host_st == CBC_HOST)
      want_sel = cbc_ones(host_mask) <= max_cnt ? host_mask : '0;
    else if (ctrl[`CBC_B_AUTO])
    begin
      // the pick lags a cycle, so mask and cap it again against live settings
      want_sel = sif.sel & in_use;
      if (cbc_ones(want_sel) > max_cnt)
        want_sel = '0;
    end
    next_hot = die_temp_valid ? die_temp > temp_lim : hot;
    next_act = hot ? '0 : want_sel & ~susp;
    next_int_sw = ctrl[`CBC_B_EXT] ? '0 : next_act;
    next_ext_fet = ctrl[`CBC_B_EXT] ? next_act : '0;
    next_cur_only = loop_done && ctrl[`CBC_B_SLOW] && |want_sel && !hot;
  end

  always_ff @(posedge clock)
  begin
    if (srst)
    begin
      hot <= 1'b0;
      act <= '0;
      int_sw <= '0;
      ext_fet <= '0;
      cur_only_req <= 1'b0;
    end
    else
    begin
      hot <= next_hot;
      act <= next_act;
      int_sw <= next_int_sw;
      ext_fet <= next_ext_fet;
      cur_only_req <= next_cur_only;
    end
  end

  // thermistor conversion window
  always_comb
  begin
    next_therm_cnt = therm_cnt;
    if (therm_start && therm_cnt == 19'h0)
      next_therm_cnt = ctrl[`CBC_B_FAST] ? 19'(THERM_CYC / 2) : 19'(THERM_CYC);
    else if (therm_cnt != 19'h0)
      next_therm_cnt = therm_cnt - 19'h1;
    next_therm_busy = next_therm_cnt != 19'h0;
  end

  always_ff @(posedge clock)
  begin
    if (srst)
    begin
      therm_cnt <= 19'h0;
      therm_busy <= 1'b0;
    end
    else
    begin
      therm_cnt <= next_therm_cnt;
      therm_busy <= next_therm_busy;
    end
  end

  // register read, one cycle later, unmapped reads zero
  always_comb
  begin
    next_rdata = 32'h0000_0000;
    if (rd)
    begin
      unique case (addr)
        `CBC_A_CTRL: next_rdata = {28'h0, ctrl};
        `CBC_A_MAXCNT: next_rdata = {29'h0, max_cnt};
        `CBC_A_INUSE: next_rdata = {27'h0, in_use};
        `CBC_A_HOSTCMD: next_rdata = {27'h0, host_mask};
        `CBC_A_HOSTLIM: next_rdata = {16'h0, host_lim};
        `CBC_A_TEMPLIM: next_rdata = {20'h0, temp_lim};
        `CBC_A_STATUS: next_rdata = {16'h0, host_sec[7:0], therm_busy, hot, host_st, act};
        default: next_rdata = time_hit ? {16'h0, time_rd} : 32'h0000_0000;
      endcase
    end
  end

  always_ff @(posedge clock)
  begin
    if (srst)
      rdata <= 32'h0000_0000;
    else
      rdata <= next_rdata;
  end

  // checks
  default clocking cb @(posedge clock); endclocking
  default disable iff (srst);

  sequence s_expire;
    host_st == CBC_HOST && host_sec >= host_lim && !cmd_wr;
  endsequence
  sequence s_off_until_cmd;
    host_st == CBC_IDLE && host_mask == '0 ##1 (host_st == CBC_IDLE || $past(cmd_wr));
  endsequence

  property p_hot_off;
    hot |=> act == '0 && int_sw == '0 && ext_fet == '0;
  endproperty
  a_hot_off: assert property (p_hot_off) else $error("bypass on while hot");

  property p_own_susp;
    meas_cell_valid && meas_cell_idx < 3'h5 |=> !act[$past(meas_cell_idx)];
  endproperty
  a_own_susp: assert property (p_own_susp) else $error("sampled cell bypassed");

  property p_nbr_susp;
    meas_cell_valid && meas_cell_idx > 3'h0 && meas_cell_idx < 3'h5
      |=> !act[$past(meas_cell_idx) - 3'h1];
  endproperty
  a_nbr_susp: assert property (p_nbr_susp) else $error("neighbour bypassed");

  property p_stack_susp;
    meas_stack |=> (act & $past(top_oh)) == '0;
  endproperty
  a_stack_susp: assert property (p_stack_susp) else $error("top cell bypassed");

  property p_max_cnt;
    ##1 cbc_ones(act) <= $past(max_cnt);
  endproperty
  a_max_cnt: assert property (p_max_cnt) else $error("too many cells balancing");

  property p_auto_nonadj;
    host_st == CBC_IDLE |=> (act & (act >> 1)) == '0 && (act & ~$past(in_use)) == '0;
  endproperty
  a_auto_nonadj: assert property (p_auto_nonadj) else $error("auto pick adjacent");

  property p_restart;
    cmd_wr |=> host_pre == 27'h0 && host_sec == 16'h0000 && host_mask == $past(wdata[4:0]);
  endproperty
  a_restart: assert property (p_restart) else $error("timer not restarted");

  property p_expire;
    s_expire |=> s_off_until_cmd;
  endproperty
  a_expire: assert property (p_expire) else $error("host balancing past limit");

  property p_ext;
    ctrl[`CBC_B_EXT] |=> int_sw == '0 && ext_fet == act;
  endproperty
  a_ext: assert property (p_ext) else $error("wrong switch kind");

  property p_slow;
    loop_done && ctrl[`CBC_B_SLOW] && host_st == CBC_HOST && !hot && cbc_ones(host_mask) <= max_cnt
      |=> cur_only_req;
  endproperty
  a_slow: assert property (p_slow) else $error("no current-only insert");

  property p_therm;
    therm_start && therm_cnt == 19'h0 |=> therm_busy [*8];
  endproperty
  a_therm: assert property (p_therm) else $error("thermistor window short");
endmodule // cbc_top

// file: core/cbc_params.svh
/*
  Offsets, field positions, reset values and timing figures of the cell
  balance control block. Assumes a 125 MHz clock and byte addressing.
*/
`ifndef CBC_PARAMS_SVH
`define CBC_PARAMS_SVH
`define CBC_A_CTRL 8'h00
`define CBC_A_MAXCNT 8'h04
`define CBC_A_INUSE 8'h08
`define CBC_A_HOSTCMD 8'h0C
`define CBC_A_HOSTLIM 8'h10
`define CBC_A_TEMPLIM 8'h14
`define CBC_A_STATUS 8'h18
`define CBC_A_TIME0 8'h20
`define CBC_A_TIME4 8'h30
`define CBC_B_AUTO 0
`define CBC_B_EXT 1
`define CBC_B_SLOW 2
`define CBC_B_FAST 3
`define CBC_RST_CTRL 4'h0
`define CBC_RST_MAXCNT 3'h2
`define CBC_RST_INUSE 5'h1F
`define CBC_RST_HOSTLIM 16'h003C
`define CBC_RST_TEMPLIM 12'hC00
`define CBC_CLK_KHZ 125000
`define CBC_TICK_MS 1000
`define CBC_THERM_US 3000
`endif

// file: core/cbc_pkg.sv
/*
  Types shared by the cell balance control modules.
  Assumes five cell positions, cell 0 at the bottom of the stack.
*/
package cbc_pkg;
  typedef logic [4:0] cbc_mask_t;
  typedef logic [2:0] cbc_cnt_t;
  // host balancing state, one bit apart
  typedef enum logic [0:0] {CBC_IDLE = 1'b0, CBC_HOST = 1'b1} cbc_hst_t;

  // number of set bits in a cell mask
  function automatic cbc_cnt_t cbc_ones(input cbc_mask_t m);
    cbc_cnt_t n;
    n = 3'h0;
    for (int i = 0; i < 5; i++)
    begin
      n = n + {2'h0, m[i]};
    end
    return n;
  endfunction
endpackage

// file: core/cbc_sel_if.sv
/*
  Carrier between the top and the autonomous cell selector.
  Assumes both ends on the same clock.
*/
interface cbc_sel_if;
  import cbc_pkg::*;
  cbc_mask_t want;
  cbc_mask_t in_use;
  cbc_cnt_t max_cnt;
  cbc_mask_t sel;
  modport top (output want, output in_use, output max_cnt, input sel);
  modport pick (input want, input in_use, input max_cnt, output sel);
endinterface

// file: core/cbc_autosel.sv
/*
  Autonomous cell picker: non-adjacent cells in use, capped in count.
  Assumes want comes from the voltage algorithm on the same clock.
*/
module cbc_autosel
  import cbc_pkg::*;
(
  input wire logic clock,
  input wire logic srst,
  cbc_sel_if.pick sif
);
  cbc_mask_t sel;
  cbc_mask_t next_sel;

  // greedy pick from the bottom, skipping neighbours of a picked cell
  always_comb
  begin
    cbc_cnt_t n;
    logic prev;
    n = 3'h0;
    prev = 1'b0;
    next_sel = '0;
    for (int i = 0; i < 5; i++)
    begin
      if (sif.want[i] && sif.in_use[i] && !prev && n < sif.max_cnt)
      begin
        next_sel[i] = 1'b1;
        n = n + 3'h1;
      end
      prev = next_sel[i];
    end
  end

  // register the pick
  always_ff @(posedge clock)
  begin
    if (srst)
      sel <= '0;
    else
      sel <= next_sel;
  end

  assign sif.sel = sel;
endmodule // cbc_autosel

// file: core/cbc_baltime.sv
/*
  Per-cell balancing time counters in seconds, saturating.
  Assumes a one-cycle tick each second and a same-clock read index.
*/
module cbc_baltime
  import cbc_pkg::*;
(
  input wire logic clock,
  input wire logic srst,
  input wire logic tick,
  input wire cbc_mask_t act,
  input wire logic clr,
  input wire logic [2:0] idx,
  output logic [15:0] rd_data
);
  logic [15:0] cnt [5];

  // one counter per cell
  genvar g;
  generate
    for (g = 0; g < 5; g++)
    begin : g_cell
      logic [15:0] next_cnt;
      always_comb
      begin
        next_cnt = cnt[g];
        if (clr && idx == 3'(g))
          next_cnt = 16'h0000;
        else if (tick && act[g] && cnt[g] != 16'hFFFF)
          next_cnt = cnt[g] + 16'h0001;
      end
      always_ff @(posedge clock)
      begin
        if (srst)
          cnt[g] <= 16'h0000;
        else
          cnt[g] <= next_cnt;
      end
    end
  endgenerate

  // read mux over the counter flops
  always_comb
  begin
    rd_data = 16'h0000;
    if (idx < 3'h5)
      rd_data = cnt[idx];
  end
endmodule // cbc_baltime

// file: tb/cbc_host_model.sv
/*
  Host model: issues register accesses and balancing commands.
  Assumes the single-cycle strobe bus and read data one cycle after rd.
*/
module cbc_host_model
(
  input wire logic clock,
  output logic [7:0] addr,
  output logic [31:0] wdata,
  output logic wr,
  output logic rd,
  input wire logic [31:0] rdata
);
  timeunit 1ns;
  timeprecision 1ps;
  initial
  begin
    addr = 8'h00;
    wdata = 32'h0;
    wr = 1'b0;
    rd = 1'b0;
  end

  // one write cycle; a command-register write is a balancing command
  task automatic put(input logic [7:0] a, input logic [31:0] d);
    @(posedge clock);
    wr <= 1'b1;
    addr <= a;
    wdata <= d;
    @(posedge clock);
    wr <= 1'b0;
  endtask

  // one read cycle, data taken in the following cycle
  task automatic get(input logic [7:0] a, output logic [31:0] d);
    @(posedge clock);
    rd <= 1'b1;
    addr <= a;
    @(posedge clock);
    rd <= 1'b0;
    #1;
    d = rdata;
  endtask
endmodule // cbc_host_model

// file: tb/test_cell_balance_control.sv
/*
  Self-checking bench of the cell balance control top.
  Assumes short tick and thermistor counts set by parameter.
*/
`include "cbc_params.svh"

module test_cell_balance_control;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int TK = 16;
  localparam int TC = 20;
  logic clock = 1'b0;
  logic srst = 1'b1;
  logic [7:0] addr;
  logic [31:0] wdata;
  logic [31:0] rdata;
  logic wr;
  logic rd;
  logic [4:0] want_mask = 5'h00;
  logic meas_cell_valid = 1'b0;
  logic [2:0] meas_cell_idx = 3'h0;
  logic meas_stack = 1'b0;
  logic loop_done = 1'b0;
  logic [11:0] die_temp = 12'h000;
  logic die_temp_valid = 1'b0;
  logic therm_start = 1'b0;
  logic [4:0] int_sw;
  logic [4:0] ext_fet;
  logic cur_only_req;
  logic therm_busy;
  logic [31:0] d;
  int err_count = 0;
  int num_checks = 0;

  // clock
  initial
  begin
    forever #4 clock = ~clock;
  end

  cbc_host_model i_host (.clock(clock), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd),
    .rdata(rdata));

  cbc_top #(.TICK_CYC(TK), .THERM_CYC(TC)) i_dut (.clock(clock), .srst(srst), .addr(addr),
    .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata), .want_mask(want_mask),
    .meas_cell_valid(meas_cell_valid), .meas_cell_idx(meas_cell_idx),
    .meas_stack(meas_stack), .loop_done(loop_done), .die_temp(die_temp),
    .die_temp_valid(die_temp_valid), .therm_start(therm_start), .int_sw(int_sw),
    .ext_fet(ext_fet), .cur_only_req(cur_only_req), .therm_busy(therm_busy));

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp)
    begin
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
      err_count++;
    end
  endtask

  task automatic cyc(input int n);
    repeat (n) @(posedge clock);
    #1;
  endtask

  // drive measurement levels, then compare the bypass mask
  task automatic meas(input logic v, input logic [2:0] i, input logic s, input logic [4:0] e);
    @(posedge clock);
    meas_cell_valid <= v;
    meas_cell_idx <= i;
    meas_stack <= s;
    cyc(2);
    chk(int_sw, e);
  endtask

  task automatic report_and_stop;
    $display("checks %0d mismatches %0d", num_checks, err_count);
    if (err_count == 0 && num_checks > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask

  task automatic t_reset;
    chk({int_sw, ext_fet, cur_only_req, therm_busy}, 32'h0);
    i_host.get(`CBC_A_CTRL, d);
    chk(d, 32'h0);
    i_host.get(`CBC_A_MAXCNT, d);
    chk(d, 32'h2);
    i_host.get(`CBC_A_INUSE, d);
    chk(d, 32'h1F);
    i_host.get(`CBC_A_HOSTLIM, d);
    chk(d, 32'h3C);
    i_host.get(`CBC_A_TEMPLIM, d);
    chk(d, 32'hC00);
    i_host.get(8'h40, d);
    chk(d, 32'h0);
    $display("t_reset done");
  endtask

  task automatic t_host;
    i_host.put(`CBC_A_MAXCNT, 32'h3);
    i_host.put(`CBC_A_HOSTCMD, 32'h3);
    cyc(3);
    chk(int_sw, 5'h03);
    i_host.get(`CBC_A_STATUS, d);
    chk(d[5:0], 6'h23);
    i_host.put(`CBC_A_HOSTCMD, 32'h5);
    meas(1'b1, 3'h0, 1'b0, 5'h04);
    meas(1'b1, 3'h1, 1'b0, 5'h00);
    meas(1'b1, 3'h3, 1'b0, 5'h01);
    meas(1'b0, 3'h0, 1'b0, 5'h05);
    i_host.put(`CBC_A_HOSTCMD, 32'h10);
    meas(1'b0, 3'h0, 1'b1, 5'h00);
    meas(1'b0, 3'h0, 1'b0, 5'h10);
    i_host.put(`CBC_A_CTRL, 32'h2);
    cyc(3);
    chk({int_sw, ext_fet}, 10'h010);
    // slow loop under host balancing
    i_host.put(`CBC_A_CTRL, 32'h4);
    @(posedge clock);
    loop_done <= 1'b1;
    @(posedge clock);
    loop_done <= 1'b0;
    #1;
    chk(cur_only_req, 1'b1);
    i_host.put(`CBC_A_CTRL, 32'h0);
    i_host.put(`CBC_A_MAXCNT, 32'h1);
    i_host.put(`CBC_A_HOSTCMD, 32'h3);
    cyc(3);
    chk(int_sw, 5'h00);
    i_host.put(`CBC_A_HOSTCMD, 32'h0);
    i_host.put(`CBC_A_MAXCNT, 32'h3);
    $display("t_host done");
  endtask

  // limit of three ticks; a repeated command must keep cell 0 on
  task automatic t_timer;
    i_host.put(`CBC_A_HOSTLIM, 32'h3);
    i_host.put(`CBC_A_TIME0, 32'h0);
    i_host.put(8'h24, 32'h0);
    i_host.put(`CBC_A_HOSTCMD, 32'h1);
    cyc(25);
    i_host.put(`CBC_A_HOSTCMD, 32'h1);
    cyc(25);
    chk(int_sw, 5'h01);
    cyc(60);
    chk(int_sw, 5'h00);
    i_host.get(`CBC_A_STATUS, d);
    chk(d[5], 1'b0);
    i_host.get(`CBC_A_HOSTCMD, d);
    chk(d, 32'h0);
    i_host.get(`CBC_A_TIME0, d);
    chk({31'h0, d >= 32'h2 && d <= 32'h6}, 32'h1);
    i_host.get(8'h24, d);
    chk(d, 32'h0);
    i_host.put(`CBC_A_HOSTLIM, 32'h3C);
    $display("t_timer done");
  endtask

  task automatic t_auto;
    i_host.put(`CBC_A_INUSE, 32'h1E);
    i_host.put(`CBC_A_CTRL, 32'h1);
    @(posedge clock);
    want_mask <= 5'h1F;
    cyc(4);
    chk(int_sw, 5'h0A);
    i_host.put(`CBC_A_MAXCNT, 32'h1);
    cyc(4);
    chk(int_sw, 5'h02);
    i_host.put(`CBC_A_CTRL, 32'h5);
    for (int k = 0; k < 2; k++)
    begin
      @(posedge clock);
      loop_done <= 1'b1;
      @(posedge clock);
      loop_done <= 1'b0;
      #1;
      chk(cur_only_req, k == 0);
      cyc(1);
      chk(cur_only_req, 1'b0);
      i_host.put(`CBC_A_CTRL, 32'h1);
    end
    @(posedge clock);
    die_temp <= 12'hC01;
    die_temp_valid <= 1'b1;
    @(posedge clock);
    die_temp_valid <= 1'b0;
    cyc(2);
    chk(int_sw, 5'h00);
    i_host.get(`CBC_A_STATUS, d);
    chk(d[6], 1'b1);
    @(posedge clock);
    die_temp <= 12'h100;
    die_temp_valid <= 1'b1;
    @(posedge clock);
    die_temp_valid <= 1'b0;
    cyc(3);
    chk(int_sw, 5'h02);
    @(posedge clock);
    want_mask <= 5'h00;
    i_host.put(`CBC_A_CTRL, 32'h0);
    $display("t_auto done");
  endtask

  // busy window length in normal and fast conversion
  task automatic t_therm;
    int n;
    for (int f = 0; f < 2; f++)
    begin
      i_host.put(`CBC_A_CTRL, f ? 32'h8 : 32'h0);
      @(posedge clock);
      therm_start <= 1'b1;
      @(posedge clock);
      therm_start <= 1'b0;
      n = 0;
      #1;
      repeat (40)
      begin
        if (therm_busy === 1'b1)
          n++;
        cyc(1);
      end
      chk(n, f ? TC / 2 : TC);
    end
    $display("t_therm done");
  endtask

  // main sequence
  initial
  begin
    repeat (20) @(posedge clock);
    srst <= 1'b0;
    cyc(1);
    t_reset();
    t_host();
    t_timer();
    t_auto();
    t_therm();
    report_and_stop();
  end

  // watchdog
  initial
  begin
    repeat (20000) @(posedge clock);
    err_count++;
    report_and_stop();
  end
endmodule // test_cell_balance_control
